// ---- hdl/bmx_exec.sv ----
/*
 Branch and memory-move execution unit, with its data FIFO.
 Assumes the fetch unit presents a whole instruction (up to three words)
 with a strobe, and a bus master moves words on a valid/ready handshake.
*/
`timescale 1ns/1ns

module bmx_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];   // Storage
   logic [AW-1:0]    wp_r;            // Write pointer
   logic [AW-1:0]    rp_r;            // Read pointer
   logic [AW:0]      cnt_r;           // Occupancy
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage writes
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Pointers and count; wrap assumes a power-of-two depth
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + AW'(1);
         if (pop)  rp_r <= rp_r + AW'(1);
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bmx_fifo

module bmx_exec
   import bmx_pkg::*;
#(
   parameter int DW = 32
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   // Instruction from fetch unit
   input  wire logic          instr_valid,
   output logic               instr_ready,
   input  wire logic [31:0]   instr_w0,
   input  wire logic [31:0]   instr_w1,
   input  wire logic [31:0]   instr_w2,
   input  wire logic [31:0]   ip_in,
   // Host writes the instruction pointer
   input  wire logic          ip_host_wr,
   input  wire logic [31:0]   ip_host_data,
   // Condition sources
   input  wire logic          alu_carry,
   input  wire logic [2:0]    latched_phase,
   input  wire logic          phase_unserviced,
   input  wire logic          target_mode,
   input  wire logic          scsi_attention_line_n,
   input  wire logic [7:0]    first_received_byte_reg,
   input  wire logic [7:0]    dma_mode_reg,
   input  wire logic          prefetch_enable,
   input  wire logic [31:0]   data_structure_addr_in,
   input  wire logic          interrupt_status_reg_clear_fly,
   // Sequencer results
   output logic               ip_load,
   output logic [31:0]        ip_next,
   output logic [31:0]        temp_reg,
   output logic [31:0]        instruction_operand_reg,
   output logic [31:0]        data_structure_addr_reg,
   output logic [7:0]         interrupt_status_reg,
   output logic               host_irq_n,
   output logic               halted,
   output logic               illegal_instr,
   output logic               prefetch_flush,
   // Bus master read side
   output logic               rd_req,
   output logic [31:0]        rd_addr,
   output logic               rd_io,
   input  wire logic          rd_valid,
   input  wire logic [DW-1:0] rd_data,
   // Bus master write side
   output logic               wr_valid,
   input  wire logic          wr_ready,
   output logic [31:0]        wr_addr,
   output logic               wr_io,
   output logic [DW-1:0]      wr_data
);
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_MOVE, S_HALT} bmx_state_t;
   bmx_state_t  st_r;                  // Control state
   logic [31:0] w0_r;                  // Held first word
   logic [31:0] w1_r;                  // Held second word
   logic [23:0] rcnt_r;                // Bytes left to read
   logic [23:0] wcnt_r;                // Bytes left to write
   logic [31:0] dst_r;                 // Destination address
   logic [31:0] dsa_save_r;            // Saved structure address
   logic        cond_true;
   logic        taken;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [DW-1:0] fifo_out_data;
   logic        accept;

   // Condition evaluation on the held instruction
   function automatic logic eval_cond(input logic [31:0] w);
      logic pc;
      logic dc;
      logic sense;
      pc = 1'b0;
      dc = 1'b0;
      sense = w[SENSE_BIT];
      if (w[CARRY_BIT]) begin
         return (alu_carry == sense);
      end
      // Masked bits always compare equal
      dc = ((first_received_byte_reg | w[MASK_HI:MASK_LO]) ==
            (w[VAL_HI:VAL_LO] | w[MASK_HI:MASK_LO]));
      pc = target_mode ? !scsi_attention_line_n
                       : (latched_phase == w[PHASE_HI:PHASE_LO]);
      if (w[DATA_BIT] && w[PHC_BIT]) begin
         return sense ? (dc && pc) : (!dc && !pc);
      end else if (w[DATA_BIT]) begin
         return (dc == sense);
      end else if (w[PHC_BIT]) begin
         return (pc == sense);
      end
      return sense;   // No test selected: unconditional when sense is true
   endfunction : eval_cond

   // A process, not an assign, so that the condition sources read inside
   // the function are part of the sensitivity and a repeated word re-evaluates
   always_comb begin
      cond_true = eval_cond(w0_r);
   end
   assign taken       = (st_r == S_WAIT) &&
                        (!w0_r[WAIT_BIT] || phase_unserviced) && cond_true;
   assign instr_ready = (st_r == S_IDLE);
   assign accept      = instr_valid && instr_ready;
   assign rd_req      = (st_r == S_MOVE) && (rcnt_r != CNT_ZERO) && fifo_in_ready;
   assign wr_valid    = (st_r == S_MOVE) && fifo_out_valid;
   assign wr_data     = fifo_out_data;

   // Data path FIFO between source bursts and destination writes
   bmx_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (rd_req && rd_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (rd_data),
      .out_valid (fifo_out_valid),
      .out_ready (wr_valid && wr_ready),
      .out_data  (fifo_out_data)
   );

   // Sequencing state and instruction dispatch
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= S_IDLE;
         w0_r <= '0;
         w1_r <= '0;
      end else begin
         unique case (st_r)
            S_IDLE: begin
               if (accept) begin
                  w0_r <= instr_w0;
                  w1_r <= instr_w1;
                  if (instr_w0[TYPE_HI:TYPE_LO] == CLS_XFER &&
                      !instr_w0[OPC_HI]) begin
                     st_r <= S_WAIT;
                  end else if (instr_w0[TYPE_HI:TYPE_LO] == CLS_MOVE &&
                               instr_w0[RSV_HI:RSV_LO] == '0 &&
                               instr_w1[1:0] == instr_w2[1:0]) begin
                     st_r <= S_MOVE;
                  end
               end
            end
            S_WAIT: begin
               // Falls through when the phase is ready but condition is false
               if (!w0_r[WAIT_BIT] || phase_unserviced) begin
                  if (taken && w0_r[OPC_HI:OPC_LO] == OP_INT && !w0_r[FLY_BIT]) begin
                     st_r <= S_HALT;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_MOVE: begin
               if (wcnt_r == CNT_ZERO) begin
                  st_r <= S_IDLE;
               end
            end
            S_HALT: begin
               if (ip_host_wr) begin
                  st_r <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Instruction pointer, return link and vector
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ip_load  <= 1'b0;
         ip_next  <= '0;
         temp_reg <= '0;
         instruction_operand_reg <= '0;
      end else begin
         ip_load <= 1'b0;
         if (accept && instr_w0[TYPE_HI:TYPE_LO] == CLS_MOVE) begin
            instruction_operand_reg <= instr_w1;
         end
         if (st_r == S_HALT && ip_host_wr) begin
            ip_load <= 1'b1;
            ip_next <= ip_host_data;
         end else if (taken) begin
            unique case (w0_r[OPC_HI:OPC_LO])
               OP_JUMP, OP_CALL: begin
                  ip_load <= 1'b1;
                  if (w0_r[REL_BIT]) begin
                     ip_next <= ip_in + {{8{w1_r[CNT_W-1]}}, w1_r[CNT_W-1:0]};
                  end else begin
                     ip_next <= w1_r + IP_STEP;
                  end
                  if (w0_r[OPC_HI:OPC_LO] == OP_CALL) begin
                     temp_reg <= ip_in;
                  end
               end
               OP_RET: begin
                  ip_load <= 1'b1;
                  ip_next <= temp_reg;
               end
               default: begin
                  instruction_operand_reg <= w1_r;
               end
            endcase
         end
      end
   end

   // Host interrupt, on-the-fly status and illegal instruction
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         host_irq_n           <= 1'b1;
         interrupt_status_reg <= '0;
         illegal_instr        <= 1'b0;
         halted               <= 1'b0;
      end else begin
         illegal_instr <= accept && instr_w0[TYPE_HI:TYPE_LO] == CLS_MOVE &&
                          (instr_w0[RSV_HI:RSV_LO] != '0 ||
                           instr_w1[1:0] != instr_w2[1:0]);
         halted <= (st_r == S_HALT) && !ip_host_wr;
         if (taken && w0_r[OPC_HI:OPC_LO] == OP_INT && !w0_r[FLY_BIT]) begin
            host_irq_n <= 1'b0;
         end else if (ip_host_wr) begin
            host_irq_n <= 1'b1;
         end
         // Set wins over a host clear in the same cycle
         if (taken && w0_r[OPC_HI:OPC_LO] == OP_INT && w0_r[FLY_BIT]) begin
            interrupt_status_reg[FLYST_BIT] <= 1'b1;
         end else if (interrupt_status_reg_clear_fly) begin
            interrupt_status_reg[FLYST_BIT] <= 1'b0;
         end
      end
   end

   // Memory move addresses, counts and holding registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rcnt_r <= '0;
         wcnt_r <= '0;
         rd_addr <= '0;
         dst_r <= '0;
         rd_io <= 1'b0;
         wr_io <= 1'b0;
         prefetch_flush <= 1'b0;
         dsa_save_r <= '0;
         data_structure_addr_reg <= '0;
      end else begin
         prefetch_flush <= 1'b0;
         if (st_r == S_IDLE) begin
            data_structure_addr_reg <= data_structure_addr_in;
         end
         if (accept && instr_w0[TYPE_HI:TYPE_LO] == CLS_MOVE) begin
            rcnt_r  <= instr_w0[CNT_W-1:0];
            wcnt_r  <= instr_w0[CNT_W-1:0];
            rd_addr <= instr_w1;
            dst_r   <= instr_w2;
            rd_io   <= dma_mode_reg[SOURCE_IO_SPACE_SELECT_BIT];
            wr_io   <= dma_mode_reg[DEST_IO_SPACE_SELECT_BIT];
            dsa_save_r <= data_structure_addr_in;
            data_structure_addr_reg <= instr_w2;
            prefetch_flush <= prefetch_enable && !instr_w0[NOFL_BIT];
         end
         if (rd_req && rd_valid) begin
            rd_addr <= rd_addr + IP_STEP;
            rcnt_r  <= (rcnt_r > WORD_BYTES) ? rcnt_r - WORD_BYTES : CNT_ZERO;
         end
         if (wr_valid && wr_ready) begin
            dst_r  <= dst_r + IP_STEP;
            wcnt_r <= (wcnt_r > WORD_BYTES) ? wcnt_r - WORD_BYTES : CNT_ZERO;
            data_structure_addr_reg <= dst_r + IP_STEP;
         end
         if (st_r == S_MOVE && wcnt_r == CNT_ZERO) begin
            data_structure_addr_reg <= dsa_save_r;
         end
      end
   end
   assign wr_addr = dst_r;

   // Checks
   halt_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
      (taken && w0_r[OPC_HI:OPC_LO] == OP_INT && !w0_r[FLY_BIT])
      |=> (!host_irq_n && st_r == S_HALT))
      else $error("halting interrupt did not raise request");
   halt_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == S_HALT && !ip_host_wr) |=> st_r == S_HALT)
      else $error("left halt without pointer write");
   fly_stat_a: assert property (@(posedge clk_sys) disable iff (rst)
      (taken && w0_r[OPC_HI:OPC_LO] == OP_INT && w0_r[FLY_BIT])
      |=> (interrupt_status_reg[FLYST_BIT] && st_r == S_IDLE && host_irq_n == $past(host_irq_n)))
      else $error("on-the-fly status not set");
   abs_target_a: assert property (@(posedge clk_sys) disable iff (rst)
      (taken && w0_r[OPC_HI:OPC_LO] == OP_JUMP && !w0_r[REL_BIT])
      |=> (ip_load && ip_next == $past(w1_r) + IP_STEP))
      else $error("absolute target wrong");
   rel_target_a: assert property (@(posedge clk_sys) disable iff (rst)
      (taken && w0_r[OPC_HI:OPC_LO] == OP_CALL && w0_r[REL_BIT])
      |=> (ip_next == $past(ip_in) + {{8{$past(w1_r[23])}}, $past(w1_r[23:0])}))
      else $error("relative target wrong");
   no_action_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == S_WAIT && !taken && st_r != S_HALT && !ip_host_wr) |=> !ip_load)
      else $error("pointer moved without action");
   wait_phase_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == S_WAIT && w0_r[WAIT_BIT] && !phase_unserviced) |=> st_r == S_WAIT)
      else $error("compare did not wait for phase");
   bad_move_a: assert property (@(posedge clk_sys) disable iff (rst)
      (accept && instr_w0[TYPE_HI:TYPE_LO] == CLS_MOVE && instr_w1[1:0] != instr_w2[1:0])
      |=> (illegal_instr && st_r == S_IDLE))
      else $error("misaligned move not refused");
   dsa_back_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == S_MOVE && wcnt_r == CNT_ZERO)
      |=> data_structure_addr_reg == $past(dsa_save_r))
      else $error("structure address not restored");
endmodule : bmx_exec

// ---- hdl/bmx_pkg.sv ----
/*
 Constants shared by the branch and memory-move execution block:
 instruction field positions, opcodes, phase codes and sizes.
 Assumes a 32-bit sequencer instruction word.
*/
package bmx_pkg;
   // Instruction class and opcode fields
   localparam int TYPE_HI   = 31;
   localparam int TYPE_LO   = 30;
   localparam int OPC_HI    = 29;
   localparam int OPC_LO    = 27;
   localparam int PHASE_HI  = 26;
   localparam int PHASE_LO  = 24;
   localparam int REL_BIT   = 23;
   localparam int CARRY_BIT = 21;
   localparam int FLY_BIT   = 20;
   localparam int SENSE_BIT = 19;
   localparam int DATA_BIT  = 18;
   localparam int PHC_BIT   = 17;
   localparam int WAIT_BIT  = 16;
   localparam int MASK_HI   = 15;
   localparam int MASK_LO   = 8;
   localparam int VAL_HI    = 7;
   localparam int VAL_LO    = 0;
   localparam int RSV_HI    = 28;
   localparam int RSV_LO    = 25;
   localparam int NOFL_BIT  = 24;
   localparam int CNT_W     = 24;
   localparam int SOURCE_IO_SPACE_SELECT_BIT  = 5;
   localparam int DEST_IO_SPACE_SELECT_BIT  = 4;
   localparam int FLYST_BIT = 2;
   // Class codes
   localparam logic [1:0] CLS_XFER = 2'h2;
   localparam logic [1:0] CLS_MOVE = 2'h3;
   // Opcodes
   localparam logic [2:0] OP_JUMP = 3'h0;
   localparam logic [2:0] OP_CALL = 3'h1;
   localparam logic [2:0] OP_RET  = 3'h2;
   localparam logic [2:0] OP_INT  = 3'h3;
   // Phase codes
   localparam logic [2:0] PH_DOUT = 3'h0;
   localparam logic [2:0] PH_DIN  = 3'h1;
   localparam logic [2:0] PH_CMD  = 3'h2;
   localparam logic [2:0] PH_STAT = 3'h3;
   localparam logic [2:0] PH_MOUT = 3'h6;
   localparam logic [2:0] PH_MIN  = 3'h7;
   // Sizes
   localparam logic [31:0] IP_STEP   = 32'h0000_0004;
   localparam logic [23:0] CNT_ZERO  = 24'h00_0000;
   localparam logic [23:0] WORD_BYTES = 24'h00_0004;
   localparam int          FIFO_DEPTH = 4;
endpackage : bmx_pkg

// ---- verification/bmx_mem_model.sv ----
/*
 System memory model for the move engine: reads return an address pattern,
 writes are stored by address. Assumes the block's read request and write
 valid/ready handshake, all on clk_sys.
*/
`timescale 1ns/1ns
module bmx_mem_model (
   // Clock and pacing
   input  wire logic        clk_sys,
   input  wire logic [1:0]  slow,
   // Read side
   input  wire logic        rd_req,
   input  wire logic [31:0] rd_addr,
   output logic             rd_valid,
   output logic [31:0]      rd_data,
   // Write side
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [31:0] wr_addr,
   input  wire logic [31:0] wr_data
);
   logic [1:0]  tick_r = 2'h0;      // Pace counter for slow answers
   logic [31:0] mem [logic [31:0]]; // Written words by address
   int          n_wr = 0;           // Words accepted so far
   initial rd_valid = 1'b0;
   initial wr_ready = 1'b0;
   // Outside a valid beat the bus shows the inverse, so stale data never matches
   assign rd_data = rd_valid ? (rd_addr ^ 32'hA5A5_0000) : ~(rd_addr ^ 32'hA5A5_0000);
   // Answer every cycle, or one cycle in four when that side is slowed
   always @(posedge clk_sys) begin
      tick_r   <= tick_r + 2'h1;
      rd_valid <= rd_req && (!slow[0] || tick_r == 2'h0);
      wr_ready <= !slow[1] || tick_r == 2'h2;
      if (wr_valid && wr_ready) begin
         mem[wr_addr] = wr_data;
         n_wr++;
      end
   end
endmodule : bmx_mem_model

// ---- verification/bmx_exec_test.sv ----
/*
 Self-checking bench for bmx_exec: branch conditions, interrupts, memory
 moves and refused moves. Assumes bmx_mem_model stands in for memory.
*/
`timescale 1ns/1ns
module bmx_exec_test;
   import bmx_pkg::*;
   // Condition bits of a transfer word, low 24 bits
   localparam logic [23:0] TRU = 24'h1 << SENSE_BIT;
   localparam logic [23:0] CAR = 24'h1 << CARRY_BIT;
   localparam logic [23:0] DAT = 24'h1 << DATA_BIT;
   localparam logic [23:0] PHC = 24'h1 << PHC_BIT;
   localparam logic [23:0] WT  = 24'h1 << WAIT_BIT;
   localparam logic [23:0] REL = 24'h1 << REL_BIT;
   localparam logic [23:0] FLY = 24'h1 << FLY_BIT;
   // Clock, reset and bookkeeping
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc = 0;
   // Block inputs
   logic        instr_valid = 1'b0, ip_host_wr = 1'b0, alu_carry = 1'b0;
   logic        phase_unserviced = 1'b0, target_mode = 1'b0, interrupt_status_reg_clear_fly = 1'b0;
   logic        scsi_attention_line_n = 1'b1, prefetch_enable = 1'b1;
   logic [1:0]  slow = 2'h0;
   logic [2:0]  latched_phase = 3'h0;
   logic [7:0]  first_received_byte_reg = 8'h00, dma_mode_reg = 8'h00;
   logic [31:0] instr_w0 = 32'h0, instr_w1 = 32'h0, instr_w2 = 32'h0;
   logic [31:0] ip_in = 32'h0000_1000, ip_host_data = 32'h0;
   logic [31:0] data_structure_addr_in = 32'h0000_0DA0;
   // Block outputs
   logic        instr_ready, ip_load, host_irq_n, halted, illegal_instr, prefetch_flush;
   logic        rd_req, rd_io, rd_valid, wr_valid, wr_ready, wr_io;
   logic [7:0]  interrupt_status_reg;
   logic [31:0] ip_next, temp_reg, instruction_operand_reg, data_structure_addr_reg;
   logic [31:0] rd_addr, rd_data, wr_addr, wr_data;

   bmx_exec bmx_exec_i (.clk_sys, .rst, .instr_valid, .instr_ready, .instr_w0, .instr_w1,
      .instr_w2, .ip_in, .ip_host_wr, .ip_host_data, .alu_carry, .latched_phase,
      .phase_unserviced, .target_mode, .scsi_attention_line_n, .first_received_byte_reg,
      .dma_mode_reg, .prefetch_enable, .data_structure_addr_in, .interrupt_status_reg_clear_fly, .ip_load,
      .ip_next, .temp_reg, .instruction_operand_reg, .data_structure_addr_reg,
      .interrupt_status_reg, .host_irq_n, .halted, .illegal_instr, .prefetch_flush, .rd_req,
      .rd_addr, .rd_io, .rd_valid, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_io, .wr_data);
   bmx_mem_model bmx_mem_model_i (.clk_sys, .slow, .rd_req, .rd_addr, .rd_valid, .rd_data,
      .wr_valid, .wr_ready, .wr_addr, .wr_data);

   // Free-running clock; the cycle ceiling cuts a hang short
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   function automatic logic [31:0] xw(input logic [2:0] op, ph, input logic [23:0] lo);
      return {CLS_XFER, op, ph, lo};
   endfunction : xw

   task automatic chk(input string what, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Offer one instruction and hold it until the edge that takes it
   task automatic issue(input logic [31:0] w0, w1, w2);
      int n;
      n = 0;
      @(negedge clk_sys);
      instr_w0 = w0;
      instr_w1 = w1;
      instr_w2 = w2;
      instr_valid = 1'b1;
      while (instr_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      instr_valid = 1'b0;
   endtask : issue

   // Watch for the one-cycle pointer load, sampled between edges
   task automatic wait_load(input int lim, output logic got, output logic [31:0] nxt);
      got = 1'b0;
      nxt = 32'h0;
      for (int i = 0; i < lim && !got; i++) begin
         @(negedge clk_sys);
         if (ip_load === 1'b1) begin
            got = 1'b1;
            nxt = ip_next;
         end
      end
   endtask : wait_load

   task automatic run(input logic [31:0] w0, w1, input logic tk, input logic [31:0] nx);
      logic        g;
      logic [31:0] v;
      issue(w0, w1, 32'h0);
      wait_load(6, g, v);
      chk("taken", {31'h0, tk}, {31'h0, g});
      if (tk) chk("target", nx, v);
   endtask : run

   task automatic cond(input logic c, input logic [2:0] lp, input logic tm, an,
         input logic [7:0] fb, input logic [2:0] pf, input logic [23:0] lo, input logic tk);
      alu_carry = c;
      latched_phase = lp;
      target_mode = tm;
      scsi_attention_line_n = an;
      first_received_byte_reg = fb;
      run(xw(OP_JUMP, pf, lo), 32'h0000_4000, tk, 32'h0000_4004);
   endtask : cond

   task automatic t_xfer();
      logic        g;
      logic [31:0] a;
      run(xw(OP_JUMP, 3'h0, TRU), 32'h0000_2000, 1'b1, 32'h0000_2004);
      run(xw(OP_JUMP, 3'h0, 24'h0), 32'h0000_2000, 1'b0, 32'h0);
      run(xw(OP_JUMP, 3'h0, TRU | REL), 32'h00FF_FFF0, 1'b1, 32'h0000_0FF0);
      run(xw(OP_CALL, 3'h0, TRU | REL), 32'h0000_0010, 1'b1, 32'h0000_1010);
      run(xw(OP_CALL, 3'h0, TRU), 32'h0000_3000, 1'b1, 32'h0000_3004);
      chk("link", ip_in, temp_reg);
      issue(xw(OP_RET, 3'h0, TRU | REL), 32'h0000_0100, 32'h0);
      wait_load(6, g, a);
      chk("return", 32'h0000_1000, a);
      for (int i = 4; i < 8; i++) run(xw(3'(i), 3'h0, TRU), 32'h0, 1'b0, 32'h0);
      $display("transfer test done");
   endtask : t_xfer

   task automatic t_cond();
      cond(1'b1, 3'h0, 1'b0, 1'b1, 8'h00, 3'h0, CAR | TRU, 1'b1);
      cond(1'b0, 3'h0, 1'b0, 1'b1, 8'h00, 3'h0, CAR | TRU, 1'b0);
      cond(1'b0, 3'h0, 1'b0, 1'b1, 8'h00, 3'h0, CAR, 1'b1);
      cond(1'b0, 3'h0, 1'b0, 1'b1, 8'hD5, 3'h0, DAT | TRU | 24'h00_7F80, 1'b1);
      cond(1'b0, 3'h0, 1'b0, 1'b1, 8'h55, 3'h0, DAT | TRU | 24'h00_7F80, 1'b0);
      for (int p = 0; p < 8; p++) begin
         cond(1'b0, 3'(p), 1'b0, 1'b1, 8'h00, 3'(p), PHC | TRU, 1'b1);
         cond(1'b0, 3'(p), 1'b0, 1'b1, 8'h00, 3'(p ^ 1), PHC | TRU, 1'b0);
      end
      cond(1'b0, PH_CMD, 1'b0, 1'b1, 8'h11, PH_CMD, PHC | DAT | TRU | 24'h22, 1'b0);
      cond(1'b0, PH_CMD, 1'b0, 1'b1, 8'h11, PH_STAT, PHC | DAT | 24'h22, 1'b1);
      cond(1'b0, PH_CMD, 1'b0, 1'b1, 8'h11, PH_CMD, PHC | DAT | 24'h22, 1'b0);
      // Target mode keeps the phase field clear
      cond(1'b0, PH_MIN, 1'b1, 1'b0, 8'h00, 3'h0, PHC | TRU, 1'b1);
      cond(1'b0, PH_MIN, 1'b1, 1'b1, 8'h00, 3'h0, PHC | TRU, 1'b0);
      target_mode = 1'b0;
      $display("condition test done");
   endtask : t_cond

   task automatic t_wait();
      logic        g;
      logic [31:0] v;
      latched_phase = PH_DIN;
      issue(xw(OP_JUMP, PH_DIN, PHC | WT | TRU), 32'h0000_6000, 32'h0);
      wait_load(6, g, v);
      chk("early", 32'h0, {31'h0, g});
      phase_unserviced = 1'b1;
      wait_load(6, g, v);
      chk("late", 32'h0000_6004, v);
      @(negedge clk_sys);
      phase_unserviced = 1'b0;
      $display("wait test done");
   endtask : t_wait

   task automatic t_int();
      logic        g;
      logic [31:0] v;
      issue(xw(OP_INT, 3'h0, TRU | REL), 32'h1234_5678, 32'h0);
      wait_load(6, g, v);
      chk("no load", 32'h0, {31'h0, g});
      chk("irq", 32'h0, {31'h0, host_irq_n});
      chk("vector", 32'h1234_5678, instruction_operand_reg);
      chk("halted", 32'h1, {31'h0, halted});
      ip_host_data = 32'h0000_5000;
      ip_host_wr = 1'b1;
      wait_load(1, g, v);
      ip_host_wr = 1'b0;
      chk("resume", 32'h0000_5000, v);
      chk("irq off", 32'h1, {31'h0, host_irq_n});
      issue(xw(OP_INT, 3'h0, TRU | FLY), 32'h0000_00AB, 32'h0);
      repeat (4) @(negedge clk_sys);
      chk("fly bit", 32'h1, {31'h0, interrupt_status_reg[FLYST_BIT]});
      chk("running", 32'h0, {31'h0, halted});
      interrupt_status_reg_clear_fly = 1'b1;
      @(negedge clk_sys);
      interrupt_status_reg_clear_fly = 1'b0;
      @(negedge clk_sys);
      chk("fly clr", 32'h0, {31'h0, interrupt_status_reg[FLYST_BIT]});
      $display("interrupt test done");
   endtask : t_int

   // Each pair of space bits, with a different stall pattern each time
   task automatic t_move();
      logic [31:0] s, d;
      logic        fl, ri, wi;
      int          base;
      for (int m = 0; m < 4; m++) begin
         s = 32'h0001_0000 + 32'(m * 64);
         d = 32'h0002_0000 + 32'(m * 64);
         dma_mode_reg = {2'h0, 2'(m), 4'h0};
         slow = 2'(m);
         fl = 1'b0;
         base = bmx_mem_model_i.n_wr;
         issue({CLS_MOVE, 1'b0, 4'h0, (m == 3), 24'h00_0020}, s, d);
         if (prefetch_flush === 1'b1) fl = 1'b1;
         for (int n = 0; n < 400 && bmx_mem_model_i.n_wr < base + 8; n++) begin
            @(negedge clk_sys);
            if (prefetch_flush === 1'b1) fl = 1'b1;
            if (rd_req === 1'b1) ri = rd_io;
            if (wr_valid === 1'b1) wi = wr_io;
         end
         repeat (3) @(negedge clk_sys);
         chk("flush", {31'h0, m != 3}, {31'h0, fl});
         chk("src io", 32'(m / 2), {31'h0, ri});
         chk("dst io", 32'(m % 2), {31'h0, wi});
         chk("dsa", 32'h0000_0DA0, data_structure_addr_reg);
         for (int k = 0; k < 8; k++)
            chk("word", (s + 32'(4 * k)) ^ 32'hA5A5_0000, bmx_mem_model_i.mem[d + 32'(4 * k)]);
      end
      slow = 2'h0;
      $display("move test done");
   endtask : t_move

   task automatic t_bad();
      logic il, rq;
      for (int r = 0; r < 5; r++) begin
         issue({CLS_MOVE, 1'b0, (r < 4) ? 4'(1 << r) : 4'h0, 1'b0, 24'h00_0008},
               32'h0003_0000, (r < 4) ? 32'h0004_0000 : 32'h0004_0002);
         il = (illegal_instr === 1'b1);
         rq = (rd_req === 1'b1);
         repeat (5) begin
            @(negedge clk_sys);
            if (illegal_instr === 1'b1) il = 1'b1;
            if (rd_req === 1'b1) rq = 1'b1;
         end
         chk("illegal", 32'h1, {31'h0, il});
         chk("no read", 32'h0, {31'h0, rq});
      end
      $display("refusal test done");
   endtask : t_bad

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // Reset values, then each scenario in turn
   initial begin
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("rst irq", 32'h1, {31'h0, host_irq_n});
      chk("rst ready", 32'h1, {31'h0, instr_ready});
      chk("rst halt", 32'h0, {31'h0, halted});
      rst = 1'b0;
      t_xfer();
      t_cond();
      t_wait();
      t_int();
      t_move();
      t_bad();
      summarize();
   end
endmodule : bmx_exec_test
